// >>> hdl/msi_pkg.sv
// Constants shared by the motion supervisor and interlock block
package msi_pkg;
    localparam int POS_W        = 32;
    localparam int FIX_W        = 32;
    localparam int FRAC_BITS    = 16;
    localparam int JERK_W       = 10;
    localparam logic [9:0] JERK_MAX = 10'h3E8;
    localparam int ABRUPT_SHIFT = 5;
    localparam int CUR_W        = 16;
    localparam int VOLT_W       = 16;
    localparam int HEAT_W       = 48;
    localparam int TIME_W       = 16;
    localparam int DIN_W        = 8;
    localparam int PVT_W        = 8;
    // Activity word bit positions
    localparam int ACT_HEAT     = 0;
    localparam int ACT_OVERCUR  = 1;
    localparam int ACT_AMPF     = 2;
    localparam int ACT_FOLLOW   = 3;
    localparam int INPUT_INHIBIT_FLAG  = 4;
    localparam int ACT_UNDERV   = 5;
    localparam int ACT_OVERV    = 6;
    localparam int ACT_INVFAULT = 7;
    localparam int ACT_OVERLOAD = 8;
    localparam int ACT_W        = 9;
    typedef enum logic [2:0] {
        MSI_IDLE   = 3'b000,
        MSI_ACCEL  = 3'b001,
        MSI_DECEL  = 3'b010,
        MSI_PLAT   = 3'b011,
        MSI_STREAM = 3'b100
    } msi_state_t;
    typedef enum logic [1:0] {
        MSI_GEN_TRAP   = 2'b00,
        MSI_GEN_CURVE  = 2'b01,
        MSI_GEN_STREAM = 2'b10
    } msi_gen_t;
endpackage : msi_pkg

// >>> hdl/msi_hold_timer.sv
// Counts ticks a condition persists and flags when it passes its hold time
`timescale 1ns/1ps
module msi_hold_timer #(
    parameter int W = 16
) (
    clk_sys,
    rst_n,
    tick,
    cond,
    hold_time,
    expired
);
    input  wire logic         clk_sys;
    input  wire logic         rst_n;
    input  wire logic         tick;
    input  wire logic         cond;
    input  wire logic [W-1:0] hold_time;
    output logic              expired;

    logic [W-1:0] count_reg;

    // Elaboration check: a one-bit counter cannot express a hold time
    if (W < 2) begin : g_bad_width
        $error("msi_hold_timer: W too small");
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (!cond) begin
            count_reg <= '0;
        end else if (tick && count_reg != '1) begin
            count_reg <= count_reg + W'(1);
        end
    end

    assign expired = cond && (count_reg > hold_time);
endmodule : msi_hold_timer

// >>> hdl/msi_heat_integrator.sv
// Squared-current heat integral with nominal subtraction, floored at zero
`timescale 1ns/1ps
module msi_heat_integrator (
    clk_sys,
    rst_n,
    tick,
    current,
    nominal_heating_current,
    heating_limit,
    heating_integral,
    over_limit
);
    input  wire logic                         clk_sys;
    input  wire logic                         rst_n;
    input  wire logic                         tick;
    input  wire logic signed [msi_pkg::CUR_W-1:0]   current;
    input  wire logic [2*msi_pkg::CUR_W-1:0]  nominal_heating_current;
    input  wire logic [msi_pkg::HEAT_W-1:0]   heating_limit;
    output logic [msi_pkg::HEAT_W-1:0]        heating_integral;
    output logic                              over_limit;

    logic [2*msi_pkg::CUR_W-1:0] square;
    logic [msi_pkg::HEAT_W:0]    sum;

    always_comb begin
        square = $unsigned((2*msi_pkg::CUR_W)'(current) * (2*msi_pkg::CUR_W)'(current));
        sum    = {1'b0, heating_integral} + (msi_pkg::HEAT_W+1)'(square);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            heating_integral <= '0;
        end else if (tick) begin
            if (sum <= (msi_pkg::HEAT_W+1)'(nominal_heating_current))
                heating_integral <= '0;
            else if (sum[msi_pkg::HEAT_W])
                heating_integral <= '1;
            else
                heating_integral <= msi_pkg::HEAT_W'(sum
                    - (msi_pkg::HEAT_W+1)'(nominal_heating_current));
        end
    end

    assign over_limit = heating_integral > heating_limit;
endmodule : msi_heat_integrator

// >>> hdl/msi_top.sv
// Motion supervisor: parameter staging, start/stop modes and interlocks
`timescale 1ns/1ps
module msi_top #(
    parameter bit AMP_FAULT_CHECK = 1'b1
) (
    clk_sys,
    rst_n,
    loop_tick,
    target_in,
    absolute_target_cmd,
    relative_target_cmd,
    speed_limit_in,
    accel_limit_in,
    decel_limit_in,
    accel_jerk_in,
    decel_jerk_in,
    generator_sel,
    start_cmd,
    smooth_stop_cmd,
    abrupt_stop_cmd,
    servo_off_cmd,
    servo_on_cmd,
    pvt_fill_level,
    pvt_start_level,
    profile_busy,
    motor_position,
    following_error,
    measured_current,
    bus_voltage,
    nominal_heating_current,
    heating_limit,
    total_current_limit,
    overcurrent_hold_time,
    following_error_limit,
    following_error_hold_time,
    auto_servo_off,
    input_fault_mask,
    undervoltage_limit,
    overvoltage_limit,
    overload_limit,
    amp_fault_in,
    inverter_fault_in,
    digital_inputs,
    flag_clear,
    target_position,
    speed_limit,
    accel_limit,
    decel_limit,
    accel_jerk,
    decel_jerk,
    active_generator,
    load_pulse,
    motion_state,
    servo_enable,
    winding_short,
    pwm_output_enable,
    heating_integral,
    activity_state
);
    input  wire logic                          clk_sys;
    input  wire logic                          rst_n;
    input  wire logic                          loop_tick;
    input  wire logic [msi_pkg::POS_W-1:0]     target_in;
    input  wire logic                          absolute_target_cmd;
    input  wire logic                          relative_target_cmd;
    input  wire logic [msi_pkg::FIX_W-1:0]     speed_limit_in;
    input  wire logic [msi_pkg::FIX_W-1:0]     accel_limit_in;
    input  wire logic [msi_pkg::FIX_W-1:0]     decel_limit_in;
    input  wire logic [msi_pkg::JERK_W-1:0]    accel_jerk_in;
    input  wire logic [msi_pkg::JERK_W-1:0]    decel_jerk_in;
    input  wire logic [1:0]                    generator_sel;
    input  wire logic                          start_cmd;
    input  wire logic                          smooth_stop_cmd;
    input  wire logic                          abrupt_stop_cmd;
    input  wire logic                          servo_off_cmd;
    input  wire logic                          servo_on_cmd;
    input  wire logic [msi_pkg::PVT_W-1:0]     pvt_fill_level;
    input  wire logic [msi_pkg::PVT_W-1:0]     pvt_start_level;
    input  wire logic                          profile_busy;
    input  wire logic [msi_pkg::POS_W-1:0]     motor_position;
    input  wire logic [msi_pkg::POS_W-1:0]     following_error;
    input  wire logic [msi_pkg::CUR_W-1:0]     measured_current;
    input  wire logic [msi_pkg::VOLT_W-1:0]    bus_voltage;
    input  wire logic [2*msi_pkg::CUR_W-1:0]   nominal_heating_current;
    input  wire logic [msi_pkg::HEAT_W-1:0]    heating_limit;
    input  wire logic [msi_pkg::CUR_W-1:0]     total_current_limit;
    input  wire logic [msi_pkg::TIME_W-1:0]    overcurrent_hold_time;
    input  wire logic [msi_pkg::POS_W-1:0]     following_error_limit;
    input  wire logic [msi_pkg::TIME_W-1:0]    following_error_hold_time;
    input  wire logic                          auto_servo_off;
    input  wire logic [msi_pkg::DIN_W-1:0]     input_fault_mask;
    input  wire logic [msi_pkg::VOLT_W-1:0]    undervoltage_limit;
    input  wire logic [msi_pkg::VOLT_W-1:0]    overvoltage_limit;
    input  wire logic [msi_pkg::CUR_W-1:0]     overload_limit;
    input  wire logic                          amp_fault_in;
    input  wire logic                          inverter_fault_in;
    input  wire logic [msi_pkg::DIN_W-1:0]     digital_inputs;
    input  wire logic [msi_pkg::ACT_W-1:0]     flag_clear;
    output logic [msi_pkg::POS_W-1:0]          target_position;
    output logic [msi_pkg::FIX_W-1:0]          speed_limit;
    output logic [msi_pkg::FIX_W-1:0]          accel_limit;
    output logic [msi_pkg::FIX_W-1:0]          decel_limit;
    output logic [msi_pkg::JERK_W-1:0]         accel_jerk;
    output logic [msi_pkg::JERK_W-1:0]         decel_jerk;
    output msi_pkg::msi_gen_t                  active_generator;
    output logic                               load_pulse;
    output msi_pkg::msi_state_t                motion_state;
    output logic                               servo_enable;
    output logic                               winding_short;
    output logic                               pwm_output_enable;
    output logic [msi_pkg::HEAT_W-1:0]         heating_integral;
    output logic [msi_pkg::ACT_W-1:0]          activity_state;

    function automatic logic [msi_pkg::JERK_W-1:0] clamp_jerk(
        input logic [msi_pkg::JERK_W-1:0] j);
        clamp_jerk = (j > msi_pkg::JERK_MAX) ? msi_pkg::JERK_MAX : j;
    endfunction : clamp_jerk

    function automatic logic [msi_pkg::POS_W-1:0] abs_val(
        input logic [msi_pkg::POS_W-1:0] v);
        abs_val = v[msi_pkg::POS_W-1] ? (~v + msi_pkg::POS_W'(1)) : v;
    endfunction : abs_val

    logic rst_s1_reg;
    logic rst_s2_reg;
    logic srst_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign srst_n = rst_s2_reg;

    // Pin synchronisers for fault and digital inputs
    logic [msi_pkg::DIN_W+1:0] pin_s1_reg;
    logic [msi_pkg::DIN_W+1:0] pin_s2_reg;
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {amp_fault_in, inverter_fault_in, digital_inputs};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    logic                      amp_fault_s;
    logic                      inv_fault_s;
    logic [msi_pkg::DIN_W-1:0] din_s;
    assign {amp_fault_s, inv_fault_s, din_s} = pin_s2_reg;

    // Buffered target: absolute value, or offset pending start
    logic [msi_pkg::POS_W-1:0] target_buf_reg;
    logic                      target_rel_reg;
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            target_buf_reg <= '0;
            target_rel_reg <= 1'b0;
        end else if (absolute_target_cmd) begin
            target_buf_reg <= target_in;
            target_rel_reg <= 1'b0;
        end else if (relative_target_cmd) begin
            target_buf_reg <= target_in;
            target_rel_reg <= 1'b1;
        end
    end

    logic stop_motion;
    logic servo_kill;
    logic pvt_auto;
    logic go;
    assign pvt_auto = (generator_sel == msi_pkg::MSI_GEN_STREAM)
                      && motion_state == msi_pkg::MSI_IDLE
                      && pvt_fill_level >= pvt_start_level;
    assign go = (start_cmd || pvt_auto) && servo_enable && !stop_motion;

    // Start transfers all buffered values in one clock edge
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            target_position  <= '0;
            speed_limit      <= '0;
            accel_limit      <= '0;
            decel_limit      <= '0;
            accel_jerk       <= '0;
            decel_jerk       <= '0;
            active_generator <= msi_pkg::MSI_GEN_TRAP;
        end else if (smooth_stop_cmd && motion_state != msi_pkg::MSI_IDLE) begin
            active_generator <= msi_pkg::MSI_GEN_TRAP;
            target_position  <= motor_position;
        end else if (abrupt_stop_cmd && motion_state != msi_pkg::MSI_IDLE) begin
            decel_limit     <= decel_limit << msi_pkg::ABRUPT_SHIFT;
            target_position <= motor_position;
        end else if (go) begin
            target_position <= target_rel_reg
                ? motor_position + target_buf_reg
                : target_buf_reg;
            speed_limit      <= speed_limit_in;
            accel_limit      <= accel_limit_in;
            decel_limit      <= decel_limit_in;
            accel_jerk       <= clamp_jerk(accel_jerk_in);
            decel_jerk       <= clamp_jerk(decel_jerk_in);
            active_generator <= msi_pkg::msi_gen_t'(generator_sel);
        end
    end

    // Pulse tells the profile generator to reload; trapezoidal mid-motion included
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            load_pulse <= 1'b0;
        end else begin
            load_pulse <= go
                || (smooth_stop_cmd && motion_state != msi_pkg::MSI_IDLE)
                || (abrupt_stop_cmd && motion_state != msi_pkg::MSI_IDLE);
        end
    end

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            motion_state <= msi_pkg::MSI_IDLE;
        end else begin
            case (motion_state)
                msi_pkg::MSI_IDLE: begin
                    if (go)
                        motion_state <= (generator_sel == msi_pkg::MSI_GEN_STREAM)
                            ? msi_pkg::MSI_STREAM : msi_pkg::MSI_ACCEL;
                end
                msi_pkg::MSI_ACCEL, msi_pkg::MSI_PLAT: begin
                    if (stop_motion || !servo_enable)
                        motion_state <= msi_pkg::MSI_IDLE;
                    else if (smooth_stop_cmd || abrupt_stop_cmd)
                        motion_state <= msi_pkg::MSI_DECEL;
                    else if (!profile_busy)
                        motion_state <= msi_pkg::MSI_IDLE;
                end
                msi_pkg::MSI_DECEL, msi_pkg::MSI_STREAM: begin
                    if (stop_motion || !servo_enable || !profile_busy)
                        motion_state <= msi_pkg::MSI_IDLE;
                    else if (smooth_stop_cmd || abrupt_stop_cmd)
                        motion_state <= msi_pkg::MSI_DECEL;
                end
                default: motion_state <= msi_pkg::MSI_IDLE;
            endcase
        end
    end

    // Interlock conditions
    logic heat_over;
    logic overcur_cond;
    logic overcur_trip;
    logic follow_cond;
    logic follow_trip;
    logic inhibit_cond;
    logic amp_cond;

    msi_heat_integrator u_heat (
        .clk_sys                 (clk_sys),
        .rst_n                   (srst_n),
        .tick                    (loop_tick),
        .current                 (measured_current),
        .nominal_heating_current (nominal_heating_current),
        .heating_limit           (heating_limit),
        .heating_integral        (heating_integral),
        .over_limit              (heat_over)
    );

    assign overcur_cond = measured_current > total_current_limit;
    msi_hold_timer #(.W(msi_pkg::TIME_W)) u_overcur (
        .clk_sys   (clk_sys),
        .rst_n     (srst_n),
        .tick      (loop_tick),
        .cond      (overcur_cond),
        .hold_time (overcurrent_hold_time),
        .expired   (overcur_trip)
    );

    assign follow_cond = abs_val(following_error) > following_error_limit;
    msi_hold_timer #(.W(msi_pkg::TIME_W)) u_follow (
        .clk_sys   (clk_sys),
        .rst_n     (srst_n),
        .tick      (loop_tick),
        .cond      (follow_cond),
        .hold_time (following_error_hold_time),
        .expired   (follow_trip)
    );

    assign inhibit_cond = |(din_s & input_fault_mask);
    assign amp_cond     = AMP_FAULT_CHECK && amp_fault_s;

    assign stop_motion = overcur_trip || follow_trip || inhibit_cond;
    assign servo_kill  = overcur_trip || amp_cond || inhibit_cond
                         || (follow_trip && auto_servo_off) || servo_off_cmd;

    // Sticky activity flags except ACT_HEAT, which follows heat_over each clock; a new event wins over a host clear
    logic [msi_pkg::ACT_W-1:0] events;
    always_comb begin
        events = '0;
        events[msi_pkg::ACT_OVERCUR]  = overcur_trip;
        events[msi_pkg::ACT_AMPF]     = amp_cond;
        events[msi_pkg::ACT_FOLLOW]   = follow_trip;
        events[msi_pkg::INPUT_INHIBIT_FLAG]  = inhibit_cond;
        events[msi_pkg::ACT_UNDERV]   = bus_voltage < undervoltage_limit;
        events[msi_pkg::ACT_OVERV]    = bus_voltage > overvoltage_limit;
        events[msi_pkg::ACT_INVFAULT] = inv_fault_s;
        events[msi_pkg::ACT_OVERLOAD] = measured_current > overload_limit;
    end

    logic [msi_pkg::ACT_W-1:0] act_reg;
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            act_reg <= '0;
        end else begin
            act_reg <= (act_reg & ~flag_clear) | events;
            act_reg[msi_pkg::ACT_HEAT] <= heat_over;
        end
    end
    assign activity_state = act_reg;

    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            servo_enable  <= 1'b0;
            winding_short <= 1'b0;
        end else if (servo_kill) begin
            servo_enable  <= 1'b0;
            winding_short <= servo_off_cmd;
        end else if (servo_on_cmd) begin
            servo_enable  <= 1'b1;
            winding_short <= 1'b0;
        end
    end

    // Drive drops one clock after a synchronised inhibit, two clocks after a synchronised inverter fault
    always_ff @(posedge clk_sys or negedge srst_n) begin
        if (!srst_n) begin
            pwm_output_enable <= 1'b0;
        end else begin
            pwm_output_enable <= servo_enable && !inhibit_cond
                                 && !act_reg[msi_pkg::ACT_INVFAULT];
        end
    end
endmodule : msi_top

// >>> tb/msi_inverter_model.sv
// Behavioural inverter stage: current, bus voltage and fault pins
`timescale 1ns/1ps
module msi_inverter_model (
    input  wire logic        amp_fault_req,
    input  wire logic        inv_fault_req,
    input  wire logic [15:0] cur_set,
    input  wire logic [15:0] volt_set,
    output logic      [15:0] measured_current,
    output logic      [15:0] bus_voltage,
    output logic             amp_fault_in,
    output logic             inverter_fault_in
);
    // Bridge protection cuts the current the moment it trips
    assign measured_current = amp_fault_req ? 16'h0000 : cur_set;
    assign amp_fault_in = amp_fault_req;
    assign inverter_fault_in = inv_fault_req;
    assign bus_voltage = volt_set;
endmodule : msi_inverter_model

// >>> tb/msi_asserts.sv
// Port assertions for the motion supervisor and interlocks
`timescale 1ns/1ps
module msi_asserts (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                start_cmd,
    input wire logic                smooth_stop_cmd,
    input wire logic                abrupt_stop_cmd,
    input wire logic                amp_fault_in,
    input wire logic                inverter_fault_in,
    input wire logic [7:0]          digital_inputs,
    input wire logic [7:0]          input_fault_mask,
    input wire logic [15:0]         bus_voltage,
    input wire logic [15:0]         undervoltage_limit,
    input wire logic                load_pulse,
    input wire msi_pkg::msi_state_t motion_state,
    input wire msi_pkg::msi_gen_t   active_generator,
    input wire logic [31:0]         decel_limit,
    input wire logic                servo_enable,
    input wire logic                pwm_output_enable,
    input wire logic [8:0]          activity_state
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_held(c); c [*4]; endsequence
    sequence s_moving(c); c && motion_state != msi_pkg::MSI_IDLE; endsequence
    sequence s_go; start_cmd && servo_enable && !smooth_stop_cmd && !abrupt_stop_cmd
        && activity_state[4:3] == 2'b00 && !activity_state[1]; endsequence
    property p_load; s_go |-> ##[1:2] load_pulse; endproperty
    a_load: assert property (p_load) else $error("start not loaded");
    property p_abrupt; s_moving(abrupt_stop_cmd && !smooth_stop_cmd)
        |=> (decel_limit == ($past(decel_limit) << 5)); endproperty
    a_abrupt: assert property (p_abrupt) else $error("abrupt decel wrong");
    property p_smooth; s_moving(smooth_stop_cmd) |=> (motion_state == msi_pkg::MSI_DECEL
        && active_generator == msi_pkg::MSI_GEN_TRAP); endproperty
    a_smooth: assert property (p_smooth) else $error("smooth stop wrong");
    property p_amp; s_held(amp_fault_in) |-> ##[0:3] (activity_state[2] && !servo_enable);
    endproperty
    a_amp: assert property (p_amp) else $error("amp fault missed");
    property p_inhibit; s_held(|(digital_inputs & input_fault_mask))
        |-> ##[0:3] (activity_state[4] && !servo_enable && !pwm_output_enable); endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit missed");
    property p_invf; s_held(inverter_fault_in)
        |-> ##[0:3] (activity_state[7] && !pwm_output_enable); endproperty
    a_invf: assert property (p_invf) else $error("inverter fault missed");
    property p_under; s_held(bus_voltage < undervoltage_limit)
        |-> ##[0:3] activity_state[5]; endproperty
    a_under: assert property (p_under) else $error("undervoltage missed");
    property p_oc_off; $rose(activity_state[1]) |-> ##[0:2] !servo_enable; endproperty
    a_oc_off: assert property (p_oc_off) else $error("servo left on");
endmodule : msi_asserts

// >>> tb/tb_msi_top.sv
// Self-checking bench for the motion supervisor and interlocks
`timescale 1ns/1ps
`define CK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_msi_top;
    localparam int C_GO = 0, C_TGT = 1, C_OFS = 2, C_SMOOTH = 3, C_HARD = 4, C_OFF = 5, C_ON = 6;
    logic        clk_sys, rst_n, loop_tick, profile_busy, auto_servo_off, amp_fault_in;
    logic        inverter_fault_in, load_pulse, servo_enable, winding_short, pwm_output_enable;
    logic        amp_fault_req, inv_fault_req;
    logic [6:0]  cmd;
    logic [31:0] target_in, speed_limit_in, accel_limit_in, decel_limit_in, motor_position;
    logic [31:0] following_error, nominal_heating_current, following_error_limit;
    logic [31:0] target_position, speed_limit, accel_limit, decel_limit;
    logic [15:0] measured_current, bus_voltage, total_current_limit, overcurrent_hold_time;
    logic [15:0] following_error_hold_time, undervoltage_limit, overvoltage_limit;
    logic [15:0] overload_limit, cur_set, volt_set;
    logic [9:0]  accel_jerk_in, decel_jerk_in, accel_jerk, decel_jerk;
    logic [7:0]  pvt_fill_level, pvt_start_level, input_fault_mask, digital_inputs;
    logic [47:0] heating_limit, heating_integral;
    logic [8:0]  flag_clear, activity_state;
    logic [1:0]  generator_sel;
    msi_pkg::msi_gen_t   active_generator;
    msi_pkg::msi_state_t motion_state;
    int          n_errors = 0;
    int          checks_done = 0;
    wire logic   start_cmd = cmd[0], absolute_target_cmd = cmd[1], relative_target_cmd = cmd[2];
    wire logic   smooth_stop_cmd = cmd[3], abrupt_stop_cmd = cmd[4];
    wire logic   servo_off_cmd = cmd[5], servo_on_cmd = cmd[6];
    msi_top u_dut (.*);
    msi_inverter_model u_inv (.*);
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt
    task automatic pulse(input int k);
        cmd[k] <= 1'b1;
        wt(1);
        cmd[k] <= 1'b0;
        wt(3);
    endtask : pulse
    task automatic tick(input int n);
        repeat (2 * n) begin
            loop_tick <= ~loop_tick;
            wt(1);
        end
        wt(2);
    endtask : tick
    task automatic clr();
        flag_clear <= 9'h1FF;
        wt(1);
        flag_clear <= 9'h000;
        wt(2);
    endtask : clr
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // The sequence needs under two hundred cycles
    initial begin
        wt(5000);
        n_errors++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        {cmd, loop_tick, profile_busy, auto_servo_off, amp_fault_req, inv_fault_req} = '0;
        {target_in, speed_limit_in, accel_limit_in, decel_limit_in, motor_position} = '0;
        {following_error, nominal_heating_current, following_error_limit, heating_limit} = '0;
        {overcurrent_hold_time, following_error_hold_time, cur_set, generator_sel} = '0;
        {accel_jerk_in, decel_jerk_in, pvt_fill_level, pvt_start_level, input_fault_mask} = '0;
        {digital_inputs, flag_clear} = '0;
        {total_current_limit, overload_limit} = {16'h0100, 16'h0080};
        {undervoltage_limit, overvoltage_limit, volt_set} = {16'h0080, 16'h0200, 16'h0100};
        wt(10);
        rst_n <= 1'b1;
        wt(3);
        `CK({servo_enable, activity_state}, 10'h000)
        pulse(C_GO);
        `CK(motion_state, msi_pkg::MSI_IDLE)
        pulse(C_ON);
        {target_in, speed_limit_in} <= {32'h0000_1234, 32'h0000_A000};
        {accel_limit_in, decel_limit_in} <= {32'h0001_8000, 32'h0000_001F};
        {accel_jerk_in, decel_jerk_in, profile_busy} <= {10'h3FF, 10'h1F4, 1'b1};
        pulse(C_TGT);
        pulse(C_GO);
        `CK(target_position, 32'h0000_1234)
        `CK(speed_limit, 32'h0000_A000)
        `CK(accel_limit, 32'h0001_8000)
        `CK({accel_jerk, decel_jerk}, {msi_pkg::JERK_MAX, 10'h1F4})
        `CK(motion_state, msi_pkg::MSI_ACCEL)
        {motor_position, target_in} <= {32'h0000_0100, 32'h0000_0050};
        speed_limit_in <= 32'h0001_0000;
        pulse(C_OFS);
        pulse(C_GO);
        `CK(target_position, 32'h0000_0150)
        `CK(speed_limit, 32'h0001_0000)
        pulse(C_HARD);
        `CK(decel_limit, 32'h0000_03E0)
        generator_sel <= 2'b01;
        pulse(C_GO);
        `CK(active_generator, msi_pkg::MSI_GEN_CURVE)
        pulse(C_SMOOTH);
        `CK(active_generator, msi_pkg::MSI_GEN_TRAP)
        pulse(C_OFF);
        `CK({servo_enable, winding_short}, 2'b01)
        profile_busy <= 1'b0;
        $display("motion done");
        volt_set <= 16'h0040;
        wt(6);
        `CK(activity_state[5], 1'b1)
        volt_set <= 16'h0300;
        wt(6);
        `CK(activity_state[6], 1'b1)
        volt_set <= 16'h0100;
        wt(4);
        `CK(activity_state[6:5], 2'b11)
        clr();
        `CK(activity_state[6:5], 2'b00)
        {cur_set, heating_limit} <= {16'h0004, 48'h0000_0000_0032};
        tick(5);
        `CK({heating_integral, activity_state[0]}, {48'h0000_0000_0050, 1'b1})
        nominal_heating_current <= 32'h0000_00FF;
        tick(1);
        `CK({heating_integral, activity_state[0]}, 49'h0)
        $display("voltage heat done");
        pulse(C_ON);
        {generator_sel, pvt_start_level, pvt_fill_level} <= {2'b10, 8'h10, 8'h0F};
        profile_busy <= 1'b1;
        wt(3);
        `CK(motion_state, msi_pkg::MSI_IDLE)
        pvt_fill_level <= 8'h10;
        wt(3);
        `CK({motion_state, active_generator}, {msi_pkg::MSI_STREAM, msi_pkg::MSI_GEN_STREAM})
        {pvt_fill_level, profile_busy} <= {8'h00, 1'b0};
        wt(2);
        {auto_servo_off, following_error_limit} <= {1'b1, 32'h0000_0064};
        {following_error_hold_time, following_error} <= {16'h0002, 32'hFFFF_FF38};
        tick(1);
        `CK(activity_state[3], 1'b0)
        tick(4);
        `CK({activity_state[3], servo_enable}, 2'b10)
        following_error <= 32'h0000_0000;
        clr();
        pulse(C_ON);
        {overcurrent_hold_time, cur_set} <= {16'h0003, 16'h0200};
        tick(2);
        `CK(activity_state[8:1], 8'h80)
        tick(4);
        `CK({activity_state[1], servo_enable}, 2'b10)
        cur_set <= 16'h0000;
        $display("following overcurrent done");
        clr();
        pulse(C_ON);
        amp_fault_req <= 1'b1;
        wt(6);
        `CK({activity_state[2], servo_enable}, 2'b10)
        amp_fault_req <= 1'b0;
        clr();
        pulse(C_ON);
        {input_fault_mask, digital_inputs} <= {8'h24, 8'hDB};
        wt(6);
        `CK({activity_state[4], servo_enable, pwm_output_enable}, 3'b011)
        digital_inputs <= 8'h04;
        wt(6);
        `CK({activity_state[4], servo_enable, pwm_output_enable}, 3'b100)
        digital_inputs <= 8'h00;
        clr();
        pulse(C_ON);
        inv_fault_req <= 1'b1;
        wt(6);
        `CK({activity_state[7], pwm_output_enable}, 2'b10)
        $display("pins done");
        complete_run();
    end
endmodule : tb_msi_top
bind msi_top msi_asserts u_chk (.*);
